// >>> ccd_seq_pkg.sv
// constants, level codes and timing counts for the frame readout sequencer
// assumes a single 250 MHz core clock and gate drivers that take level codes
// Notes on behaviour
// - pulse overflow drain gate during exposure
// - hold overflow drain gate intermediate during readout
// - one image gate pulse moves one line
// - shift until the whole serial register empties
// - clear sweep: 165 image pulses, no shifting
// - gate rates: 1.5, 10 and 2 MHz
// - image and transfer pulses high 350 ns
// - transfer pulse rises not before image gate
// - transfer falls 350 ns after image fall
// - equal rises stretch fall gap to 700 ns
// - 70 ns before first ordinary shift pulse
// - image gate rises after last shift fall
package ccd_seq_pkg;

   // ***************************************************************
   // clock and geometry
   // ***************************************************************
   localparam int CLK_MHZ    = 250;
   localparam int NS_PER_US  = 1000;
   localparam int KHZ_PER_MHZ = 1000;
   localparam int LINES      = 165;
   localparam int DUMMY_PIX  = 6;
   localparam int IMAGE_PIX  = 192;
   localparam int DARK_PIX   = 12;
   localparam int LINE_PIX   = DUMMY_PIX + IMAGE_PIX + DARK_PIX;

   // ***************************************************************
   // timing, printed figures and derived cycle counts
   // ***************************************************************
   localparam int IMG_MAX_KHZ = 1500;
   localparam int SER_MAX_KHZ = 10000;
   localparam int DRN_MAX_KHZ = 2000;
   localparam int TW_NS       = 350;
   localparam int T3_EQ_NS    = 700;
   localparam int T4_NS       = 70;
   localparam int LINE_GAP_NS = 100;
   localparam int HALF_DIV    = 2 * KHZ_PER_MHZ;
   // least times round up
   localparam int IMG_HI_CYC  = (TW_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   localparam int XFER_TAIL_CYC = (T3_EQ_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   localparam int SETTLE_CYC  = (T4_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   localparam int GAP_CYC     = (LINE_GAP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   localparam int IMG_HALF_CYC =
      (CLK_MHZ * KHZ_PER_MHZ * KHZ_PER_MHZ + HALF_DIV * IMG_MAX_KHZ - 1)
      / (HALF_DIV * IMG_MAX_KHZ);
   localparam int SER_HALF_CYC =
      (CLK_MHZ * KHZ_PER_MHZ * KHZ_PER_MHZ + HALF_DIV * SER_MAX_KHZ - 1)
      / (HALF_DIV * SER_MAX_KHZ);
   localparam int DRN_HALF_CYC =
      (CLK_MHZ * KHZ_PER_MHZ * KHZ_PER_MHZ + HALF_DIV * DRN_MAX_KHZ - 1)
      / (HALF_DIV * DRN_MAX_KHZ);
   // clear sweep low time keeps the image gate under its rate
   localparam int IMG_LO_CYC  = (IMG_HI_CYC > IMG_HALF_CYC) ? IMG_HI_CYC : IMG_HALF_CYC;
   localparam int IDLE_CYC    = 1;

   // ***************************************************************
   // level and pixel codes
   // ***************************************************************
   localparam logic [1:0] LVL_LOW    = 2'h0;
   localparam logic [1:0] LVL_MID    = 2'h1;
   localparam logic [1:0] LVL_HIGH   = 2'h2;
   localparam logic [1:0] KIND_DUMMY = 2'h0;
   localparam logic [1:0] KIND_IMAGE = 2'h1;
   localparam logic [1:0] KIND_DARK  = 2'h2;

endpackage

// >>> phase_timer.sv
// down counter that times one sequencer phase
// assumes load comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module phase_timer
#(
   parameter int W = 16
)
(
   input  wire logic         CORE_CLK,
   input  wire logic         NRST,
   input  wire logic         ce,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              expired
);

   typedef struct packed {
      logic [W-1:0] cnt;
   } tmr_s;

   tmr_s r;
   tmr_s next_r;

   // ***************************************************************
   // count
   // ***************************************************************
   always_comb begin
      next_r = r;
      if (load) begin
         next_r.cnt = value - W'(1);
      end else if (r.cnt != '0) begin
         next_r.cnt = r.cnt - W'(1);
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign expired = (r.cnt == '0);

   timer_load_a: assert property (@(posedge CORE_CLK) disable iff (!NRST || !ce)
      load && value > W'(1) |=> !expired)
      else $error("phase timer expired right after a long load");

endmodule
`default_nettype wire

// >>> ccd_frame_readout_sequencer.sv
// gate sequencer for a full-frame sensor: exposure burst, line transfer, shift out
// assumes START, CLEAR and settings come from logic on CORE_CLK; levels go to drivers
`timescale 1ns/1ps
`default_nettype none
module ccd_frame_readout_sequencer
   import ccd_seq_pkg::*;
#(
   parameter int PULSE_W = 16
)
(
   input  wire logic               CORE_CLK,
   input  wire logic               NRST,
   input  wire logic               CE,
   input  wire logic               START,
   input  wire logic               CLEAR,
   input  wire logic               DRAIN_ENABLE,
   input  wire logic [PULSE_W-1:0] EXPOSE_PULSES,
   output logic      [1:0]         IMAGE_LINE_GATE,
   output logic                    SERIAL_SHIFT_GATE,
   output logic      [1:0]         OVERFLOW_DRAIN_GATE,
   output logic                    SAMPLE,
   output logic      [1:0]         PIXEL_KIND,
   output logic                    LINE_START,
   output logic                    FRAME_START,
   output logic                    FRAME_DONE,
   output logic                    BUSY
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef enum logic [3:0] {
      IDLE, EXP_HI, EXP_LO, XFER_BOTH, XFER_TAIL, SETTLE, SHIFT_HI, SHIFT_LO, LINE_GAP
   } phase_e;

   typedef struct packed {
      phase_e             st;
      logic               clr;
      logic               drn_en;
      logic [PULSE_W-1:0] pulses;
      logic [7:0]         line;
      logic [7:0]         pix;
      logic [1:0]         img;
      logic               ser;
      logic [1:0]         drn;
      logic               sample;
      logic [1:0]         kind;
      logic               line_start;
      logic               frame_start;
      logic               frame_done;
      logic               busy;
   } seq_s;

   localparam seq_s RST_SEQ = '{st: IDLE, clr: 1'b0, drn_en: 1'b0, pulses: '0,
      line: 8'h00, pix: 8'h00, img: LVL_LOW, ser: 1'b0, drn: LVL_MID, sample: 1'b0,
      kind: KIND_DUMMY, line_start: 1'b0, frame_start: 1'b0, frame_done: 1'b0,
      busy: 1'b0};

   seq_s        r;
   seq_s        next_r;
   logic        tload;
   logic [15:0] tval;
   logic        texp;
   logic        eol;

   function automatic logic [15:0] phase_len(input phase_e p, input logic clr);
      logic [15:0] n;
      n = 16'(IDLE_CYC);
      unique case (p)
         IDLE:      n = 16'(IDLE_CYC);
         EXP_HI:    n = 16'(DRN_HALF_CYC);
         EXP_LO:    n = 16'(DRN_HALF_CYC);
         XFER_BOTH: n = 16'(IMG_HI_CYC);
         XFER_TAIL: n = 16'(XFER_TAIL_CYC);
         SETTLE:    n = 16'(SETTLE_CYC);
         SHIFT_HI:  n = 16'(SER_HALF_CYC);
         SHIFT_LO:  n = 16'(SER_HALF_CYC);
         LINE_GAP:  n = clr ? 16'(IMG_LO_CYC) : 16'(GAP_CYC);
      endcase
      return n;
   endfunction

   function automatic logic [1:0] pix_kind(input logic [7:0] pix);
      logic [1:0] k;
      k = KIND_DARK;
      if (pix < 8'(DUMMY_PIX)) begin
         k = KIND_DUMMY;
      end else if (pix < 8'(DUMMY_PIX + IMAGE_PIX)) begin
         k = KIND_IMAGE;
      end
      return k;
   endfunction

   phase_timer #(
      .W (16)
   ) u_timer (
      .CORE_CLK (CORE_CLK),
      .NRST     (NRST),
      .ce       (CE),
      .load     (tload),
      .value    (tval),
      .expired  (texp)
   );

   // ***************************************************************
   // sequencing
   // ***************************************************************
   always_comb begin
      next_r = r;
      eol = 1'b0;
      next_r.sample = 1'b0;
      next_r.frame_start = 1'b0;
      next_r.frame_done = 1'b0;
      unique case (r.st)
         IDLE: begin
            // start wins over clear when both arrive together
            if (START) begin
               next_r.clr = 1'b0;
               next_r.drn_en = DRAIN_ENABLE;
               next_r.pulses = EXPOSE_PULSES;
               next_r.line = 8'h00;
               next_r.frame_start = 1'b1;
               next_r.st = (EXPOSE_PULSES == '0) ? XFER_BOTH : EXP_HI;
            end else if (CLEAR) begin
               next_r.clr = 1'b1;
               next_r.line = 8'h00;
               next_r.frame_start = 1'b1;
               next_r.st = XFER_BOTH;
            end
         end
         EXP_HI: begin
            if (texp) begin
               next_r.st = EXP_LO;
            end
         end
         EXP_LO: begin
            if (texp) begin
               next_r.pulses = r.pulses - PULSE_W'(1);
               next_r.st = (r.pulses == PULSE_W'(1)) ? XFER_BOTH : EXP_HI;
            end
         end
         XFER_BOTH: begin
            if (texp) begin
               if (r.clr) begin
                  eol = 1'b1;
               end else begin
                  next_r.st = XFER_TAIL;
               end
            end
         end
         XFER_TAIL: begin
            if (texp) begin
               next_r.st = SETTLE;
            end
         end
         SETTLE: begin
            if (texp) begin
               next_r.pix = 8'h00;
               next_r.st = SHIFT_HI;
            end
         end
         SHIFT_HI: begin
            if (texp) begin
               next_r.sample = 1'b1;
               next_r.kind = pix_kind(r.pix);
               next_r.st = SHIFT_LO;
            end
         end
         SHIFT_LO: begin
            if (texp) begin
               // the dummy packets must reach the amplifier too
               if (r.pix == 8'(LINE_PIX - 1)) begin
                  eol = 1'b1;
               end else begin
                  next_r.pix = r.pix + 8'h01;
                  next_r.st = SHIFT_HI;
               end
            end
         end
         LINE_GAP: begin
            if (texp) begin
               next_r.st = XFER_BOTH;
            end
         end
      endcase
      if (eol) begin
         if (r.line == 8'(LINES - 1)) begin
            next_r.frame_done = 1'b1;
            next_r.st = IDLE;
         end else begin
            next_r.line = r.line + 8'h01;
            next_r.st = LINE_GAP;
         end
      end
      next_r.line_start = (next_r.st == XFER_BOTH) && (r.st != XFER_BOTH);

      // levels follow the coming phase so the pins come from flops
      next_r.img = LVL_LOW;
      next_r.ser = 1'b0;
      next_r.drn = LVL_MID;
      unique case (next_r.st)
         EXP_HI:    next_r.drn = next_r.drn_en ? LVL_HIGH : LVL_MID;
         EXP_LO:    next_r.drn = next_r.drn_en ? LVL_LOW : LVL_MID;
         XFER_BOTH: begin
            next_r.img = LVL_HIGH;
            next_r.ser = !next_r.clr;
         end
         XFER_TAIL: next_r.ser = 1'b1;
         SHIFT_HI:  next_r.ser = 1'b1;
         IDLE, SETTLE, SHIFT_LO, LINE_GAP: begin
         end
      endcase
      next_r.busy = (next_r.st != IDLE);
      tload = (next_r.st != r.st);
      tval = phase_len(next_r.st, next_r.clr);
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         r <= RST_SEQ;
      end else if (CE) begin
         r <= next_r;
      end
   end

   assign IMAGE_LINE_GATE = r.img;
   assign SERIAL_SHIFT_GATE = r.ser;
   assign OVERFLOW_DRAIN_GATE = r.drn;
   assign SAMPLE = r.sample;
   assign PIXEL_KIND = r.kind;
   assign LINE_START = r.line_start;
   assign FRAME_START = r.frame_start;
   assign FRAME_DONE = r.frame_done;
   assign BUSY = r.busy;

   // ***************************************************************
   // checks
   // ***************************************************************
   logic        img_hi;
   logic        ser_hi;
   logic        drn_hi;
   logic [15:0] img_hi_cnt;
   logic [15:0] img_lo_cnt;
   logic [15:0] ser_hi_cnt;
   logic [15:0] ser_lo_cnt;
   logic [15:0] drn_hi_cnt;
   logic [15:0] samp_cnt;
   logic [15:0] line_cnt;
   logic [15:0] drn_rises;
   logic [PULSE_W-1:0] req;

   assign img_hi = (IMAGE_LINE_GATE == LVL_HIGH);
   assign ser_hi = SERIAL_SHIFT_GATE;
   assign drn_hi = (OVERFLOW_DRAIN_GATE == LVL_HIGH);

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction

   // counters see only enabled cycles, like the sequencer itself
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         img_hi_cnt <= 16'h0000;
         // reset counts as a long low time: a pulse right after it is legal
         img_lo_cnt <= 16'hFFFF;
         ser_hi_cnt <= 16'h0000;
         ser_lo_cnt <= 16'hFFFF;
         drn_hi_cnt <= 16'h0000;
         samp_cnt <= 16'h0000;
         line_cnt <= 16'h0000;
         drn_rises <= 16'h0000;
         req <= '0;
      end else if (CE) begin
         img_hi_cnt <= img_hi ? sat_inc(img_hi_cnt) : 16'h0000;
         img_lo_cnt <= img_hi ? 16'h0000 : sat_inc(img_lo_cnt);
         ser_hi_cnt <= ser_hi ? sat_inc(ser_hi_cnt) : 16'h0000;
         ser_lo_cnt <= ser_hi ? 16'h0000 : sat_inc(ser_lo_cnt);
         drn_hi_cnt <= drn_hi ? sat_inc(drn_hi_cnt) : 16'h0000;
         samp_cnt <= LINE_START ? 16'h0000 : samp_cnt + 16'(SAMPLE);
         line_cnt <= FRAME_START ? 16'(LINE_START) : line_cnt + 16'(LINE_START);
         drn_rises <= FRAME_START ? 16'(drn_hi && drn_hi_cnt == 16'h0000)
            : drn_rises + 16'(drn_hi && drn_hi_cnt == 16'h0000);
         if (START && r.st == IDLE) begin
            req <= EXPOSE_PULSES;
         end
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST || !CE);

   sequence xfer_rise;
      $rose(img_hi) && !r.clr;
   endsequence

   sequence line_end;
      $rose(img_hi) && !r.clr && (r.line != 8'h00);
   endsequence

   img_width_a: assert property ($fell(img_hi) |-> img_hi_cnt >= IMG_HI_CYC)
      else $error("image gate pulse too short");
   ser_width_a: assert property ($fell(ser_hi) |-> ser_hi_cnt >= SER_HALF_CYC)
      else $error("serial gate high too short");
   ser_low_a: assert property ($rose(ser_hi) |-> ser_lo_cnt >= SER_HALF_CYC)
      else $error("serial gate low too short");
   drn_width_a: assert property ($fell(drn_hi) |-> drn_hi_cnt >= DRN_HALF_CYC)
      else $error("drain gate high too short");
   xfer_rise_a: assert property (xfer_rise |-> ser_hi ##1 (img_hi && ser_hi)[*8])
      else $error("transfer pulse not rising with image gate");
   xfer_tail_a: assert property ($fell(ser_hi) && $past(r.st) == XFER_TAIL
      |-> img_lo_cnt >= XFER_TAIL_CYC)
      else $error("transfer pulse fell too soon after image gate");
   settle_a: assert property ($rose(ser_hi) && !img_hi && r.pix == 8'h00
      |-> ser_lo_cnt >= SETTLE_CYC)
      else $error("first shift pulse too close to transfer");
   line_order_a: assert property ($rose(img_hi) |-> ser_lo_cnt > 16'h0000)
      else $error("image gate rose while serial gate high");
   line_mark_a: assert property (LINE_START == $rose(img_hi))
      else $error("line marker not on image gate rise");
   shift_all_a: assert property (line_end |-> samp_cnt == 16'(LINE_PIX))
      else $error("line not fully shifted out");
   frame_lines_a: assert property (FRAME_DONE && !r.clr
      |-> line_cnt == 16'(LINES) && samp_cnt == 16'(LINE_PIX))
      else $error("frame line or pixel count wrong");
   drn_hold_a: assert property (r.st inside {XFER_BOTH, XFER_TAIL, SETTLE, SHIFT_HI,
      SHIFT_LO, LINE_GAP} |-> OVERFLOW_DRAIN_GATE == LVL_MID)
      else $error("drain gate not intermediate during readout");
   burst_a: assert property (LINE_START && line_cnt == 16'h0000 && !r.clr && r.drn_en
      |-> drn_rises == 16'(req))
      else $error("drain gate burst count wrong");
   clear_quiet_a: assert property (r.clr && BUSY |-> !SERIAL_SHIFT_GATE)
      else $error("serial gate pulsed during clear sweep");

endmodule
`default_nettype wire

// >>> ccd_sensor_model.sv
// behavioural sensor: counts line moves and shifts, measures gate timing
// assumes gate level codes from the sequencer, sampled on CORE_CLK
`timescale 1ns/1ps
`default_nettype none
module ccd_sensor_model
   import ccd_seq_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        restart,
   input  wire logic [1:0]  img,
   input  wire logic        ser,
   input  wire logic [1:0]  drn,
   output logic      [15:0] lines,
   output logic      [15:0] shifts,
   output logic      [15:0] drn_cnt,
   output logic      [15:0] img_min,
   output logic      [15:0] ser_min,
   output logic      [15:0] drn_min,
   output logic      [15:0] xfer_gap,
   output logic      [15:0] settle,
   output logic      [15:0] viol
);
   // ***************************************************************
   // gate watching
   // ***************************************************************
   logic [1:0]  p_img;
   logic [1:0]  p_drn;
   logic        p_ser;
   logic        in_xfer;
   logic        after_xfer;
   logic [15:0] img_run;
   logic [15:0] ser_run;
   logic [15:0] drn_run;

   always @(posedge CORE_CLK) begin
      p_img <= img;
      p_ser <= ser;
      p_drn <= drn;
      if (restart) begin
         lines      <= '0;
         shifts     <= '0;
         drn_cnt    <= '0;
         viol       <= '0;
         xfer_gap   <= '0;
         settle     <= '0;
         img_min    <= 16'hffff;
         ser_min    <= 16'hffff;
         drn_min    <= 16'hffff;
         // long first runs: partial runs after restart never count as short
         img_run    <= 16'h8000;
         ser_run    <= 16'h8000;
         drn_run    <= 16'h8000;
         in_xfer    <= 1'b0;
         after_xfer <= 1'b0;
      end else begin
         img_run <= (img != p_img) ? 16'h0001 : img_run + 16'h0001;
         ser_run <= (ser != p_ser) ? 16'h0001 : ser_run + 16'h0001;
         drn_run <= (drn != p_drn) ? 16'h0001 : drn_run + 16'h0001;
         if (img != p_img && img_run < img_min) img_min <= img_run;
         if (ser != p_ser && ser_run < ser_min) ser_min <= ser_run;
         if (drn != p_drn && drn_run < drn_min) drn_min <= drn_run;
         if (drn == LVL_HIGH && p_drn != LVL_HIGH) drn_cnt <= drn_cnt + 16'h0001;
         if (img == LVL_HIGH && p_img != LVL_HIGH) begin
            // a new line loads the whole serial register: shift count restarts at zero
            lines   <= lines + 16'h0001;
            shifts  <= '0;
            in_xfer <= ser;
            if (p_ser) viol <= viol + 16'h0001;
         end else if (ser && !p_ser) begin
            shifts     <= shifts + 16'h0001;
            after_xfer <= 1'b0;
            if (after_xfer) settle <= ser_run;
         end
         if (in_xfer && !ser && p_ser) begin
            xfer_gap   <= img_run;
            in_xfer    <= 1'b0;
            after_xfer <= 1'b1;
            if (img != LVL_LOW) viol <= viol + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// >>> ccd_frame_readout_sequencer_tb_top.sv
// testbench: clear sweep, frame lines with and without drain burst, freeze
// assumes the sensor model beside the sequencer; no full frame, it is too long
`timescale 1ns/1ps
`default_nettype none
module ccd_frame_readout_sequencer_tb_top;
   import ccd_seq_pkg::*;
   // ***************************************************************
   // signals and instances
   // ***************************************************************
   logic        CORE_CLK      = 1'b0;
   logic        NRST          = 1'b0;
   logic        CE            = 1'b1;
   logic        START         = 1'b0;
   logic        CLEAR         = 1'b0;
   logic        DRAIN_ENABLE  = 1'b0;
   logic [15:0] EXPOSE_PULSES = 16'h0000;
   logic        restart       = 1'b1;
   logic [1:0]  img;
   logic        ser;
   logic [1:0]  drn;
   logic        SAMPLE;
   logic [1:0]  PIXEL_KIND;
   logic        LINE_START;
   logic        FRAME_START;
   logic        FRAME_DONE;
   logic        BUSY;
   logic [15:0] lines;
   logic [15:0] shifts;
   logic [15:0] drn_cnt;
   logic [15:0] img_min;
   logic [15:0] ser_min;
   logic [15:0] drn_min;
   logic [15:0] xfer_gap;
   logic [15:0] settle;
   logic [15:0] viol;
   int          n_mismatch    = 0;
   int          check_count   = 0;

   always #2 CORE_CLK = ~CORE_CLK;

   ccd_frame_readout_sequencer uut (.CORE_CLK(CORE_CLK), .NRST(NRST), .CE(CE),
      .START(START), .CLEAR(CLEAR), .DRAIN_ENABLE(DRAIN_ENABLE),
      .EXPOSE_PULSES(EXPOSE_PULSES), .IMAGE_LINE_GATE(img), .SERIAL_SHIFT_GATE(ser),
      .OVERFLOW_DRAIN_GATE(drn), .SAMPLE(SAMPLE), .PIXEL_KIND(PIXEL_KIND),
      .LINE_START(LINE_START), .FRAME_START(FRAME_START), .FRAME_DONE(FRAME_DONE),
      .BUSY(BUSY));

   ccd_sensor_model sensor (.CORE_CLK(CORE_CLK), .restart(restart), .img(img),
      .ser(ser), .drn(drn), .lines(lines), .shifts(shifts), .drn_cnt(drn_cnt),
      .img_min(img_min), .ser_min(ser_min), .drn_min(drn_min), .xfer_gap(xfer_gap),
      .settle(settle), .viol(viol));

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic check_ge(input logic [15:0] seen, input int lim);
      check(32'(seen >= lim), 32'h0000_0001);
   endtask

   // inputs move 1 ns after the edge, outputs are settled there too
   task automatic tick(input int n);
      repeat (n) @(posedge CORE_CLK);
      #1;
   endtask

   task automatic wait_until(input int sel, input int bound);
      int i;
      for (i = 0; i < bound; i++) begin
         tick(1);
         if ((sel == 0 && SAMPLE === 1'b1) || (sel == 1 && LINE_START === 1'b1) ||
             (sel == 2 && FRAME_DONE === 1'b1)) break;
      end
      if (i == bound) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t wait ran out", $time);
         summarize();
      end
   endtask

   task automatic fresh();
      restart = 1'b1;
      tick(1);
      restart = 1'b0;
   endtask

   task automatic do_reset();
      NRST = 1'b0;
      tick(5);
      check(img, LVL_LOW);
      check(ser, 1'b0);
      check(drn, LVL_MID);
      check(BUSY, 1'b0);
      check(FRAME_START, 1'b0);
      NRST = 1'b1;
      tick(1);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_clear();
      fresh();
      CLEAR = 1'b1;
      tick(1);
      CLEAR = 1'b0;
      check(FRAME_START, 1'b1);
      check(BUSY, 1'b1);
      tick(100);
      START = 1'b1;
      tick(1);
      START = 1'b0;
      check(FRAME_START, 1'b0);
      wait_until(2, 40000);
      check(BUSY, 1'b0);
      check(lines, LINES);
      check(shifts, 16'h0000);
      check_ge(img_min, IMG_LO_CYC);
   endtask

   task automatic t_frame();
      int          k;
      int          ln;
      logic [1:0]  exp_kind;
      fresh();
      DRAIN_ENABLE  = 1'b1;
      EXPOSE_PULSES = 16'h0003;
      START         = 1'b1;
      tick(1);
      START = 1'b0;
      check(FRAME_START, 1'b1);
      check(drn, LVL_HIGH);
      wait_until(1, 1000);
      check(drn_cnt, 16'h0003);
      check_ge(drn_min, DRN_HALF_CYC);
      check(img, LVL_HIGH);
      check(ser, 1'b1);
      for (ln = 0; ln < 2; ln++) begin
         for (k = 0; k < LINE_PIX; k++) begin
            wait_until(0, 400);
            exp_kind = (k < DUMMY_PIX) ? KIND_DUMMY :
                       (k < DUMMY_PIX + IMAGE_PIX) ? KIND_IMAGE : KIND_DARK;
            check(PIXEL_KIND, exp_kind);
            check(drn, LVL_MID);
         end
         check(shifts, LINE_PIX);
         wait_until(1, 100);
      end
      // the model sees the pins one edge late
      tick(1);
      check(lines, 16'h0003);
      check_ge(xfer_gap, XFER_TAIL_CYC);
      check_ge(settle, SETTLE_CYC);
      check_ge(ser_min, SER_HALF_CYC);
      check_ge(img_min, IMG_HI_CYC);
      check(viol, 16'h0000);
      check(BUSY, 1'b1);
      // abort mid-frame: a full frame runs near a million cycles
      do_reset();
   endtask

   task automatic t_noabg();
      fresh();
      DRAIN_ENABLE  = 1'b0;
      EXPOSE_PULSES = 16'h0000;
      START         = 1'b1;
      CLEAR         = 1'b1;
      tick(1);
      START = 1'b0;
      CLEAR = 1'b0;
      check(FRAME_START, 1'b1);
      check(LINE_START, 1'b1);
      check(ser, 1'b1);
      check(drn, LVL_MID);
      tick(40);
      CE = 1'b0;
      tick(20);
      check(img, LVL_HIGH);
      check(lines, 16'h0001);
      CE = 1'b1;
      tick(1);
      check(drn_cnt, 16'h0000);
      do_reset();
   endtask

   initial begin
      do_reset();
      t_clear();
      t_frame();
      t_noabg();
      summarize();
   end
endmodule
`default_nettype wire
